// [rtl/csf_shift_bit.sv]
// Shift-through-carry and single-bit manipulation unit
`timescale 1ns/1ps
`default_nettype none

module csf_shift_bit (
	input wire csf_pkg::csf_op_e i_op,
	input wire logic [7:0] i_data,
	input wire logic [2:0] i_bit_sel,
	input wire logic i_cf,
	output logic [7:0] o_result,
	output logic o_cf,
	output logic o_zf
);
	wire logic old_bit = i_data[i_bit_sel];
	wire logic [7:0] bit_mask = 8'h01 << i_bit_sel;

	always_comb begin
		o_result = i_data;
		o_cf = i_cf;
		unique case (i_op)
			csf_pkg::CSF_OP_SHLC: begin
				o_result = {i_data[6:0], 1'b0};
				o_cf = i_data[7];
			end
			csf_pkg::CSF_OP_SHRC: begin
				o_result = {1'b0, i_data[7:1]};
				o_cf = i_data[0];
			end
			csf_pkg::CSF_OP_ROLC: begin
				o_result = {i_data[6:0], i_cf};
				o_cf = i_data[7];
			end
			csf_pkg::CSF_OP_RORC: begin
				o_result = {i_cf, i_data[7:1]};
				o_cf = i_data[0];
			end
			csf_pkg::CSF_OP_BSET: o_result = i_data | bit_mask;
			csf_pkg::CSF_OP_BCLR: o_result = i_data & ~bit_mask;
			csf_pkg::CSF_OP_BCPL: o_result = i_data ^ bit_mask;
			default: o_result = i_data;
		endcase
	end

	// Zero flag reflects the bit before it is modified
	assign o_zf = ~old_bit;

endmodule : csf_shift_bit

`default_nettype wire

// [rtl/csf_stack_seq.sv]
// Stack pointer and byte-wise push and pop sequencer
`timescale 1ns/1ps
`default_nettype none

module csf_stack_seq (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire csf_pkg::csf_stk_e i_req,
	input wire logic [15:0] i_pc,
	input wire logic [7:0] i_psw,
	input wire logic i_sp_load,
	input wire logic [15:0] i_sp_data,
	input wire logic [7:0] i_stk_rdata,
	output logic o_busy,
	output logic [15:0] o_sp,
	output logic [15:0] o_stk_addr,
	output logic o_stk_we,
	output logic o_stk_re,
	output logic [7:0] o_stk_wdata,
	output logic o_pc_load,
	output logic [15:0] o_pc,
	output logic o_psw_load,
	output logic [7:0] o_psw
);
	typedef enum logic [2:0] {
		S_IDLE, S_PUSH_PSW, S_PUSH_PCH, S_PUSH_PCL,
		S_POP_PCL, S_POP_PCH, S_POP_PSW
	} csf_stk_state_e;

	csf_stk_state_e state_r, state_nxt;
	csf_pkg::csf_stk_e kind_r;
	logic [15:0] pc_r, sp_r;
	logic [7:0] psw_r;

	wire logic idle = (state_r == S_IDLE);
	wire logic take = idle && (i_req != csf_pkg::CSF_STK_NONE);
	wire logic pushing = (state_r == S_PUSH_PSW) ||
		(state_r == S_PUSH_PCH) || (state_r == S_PUSH_PCL);
	wire logic popping = (state_r == S_POP_PCL) ||
		(state_r == S_POP_PCH) || (state_r == S_POP_PSW);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			S_IDLE: begin
				unique case (i_req)
					csf_pkg::CSF_STK_INTR: state_nxt = S_PUSH_PSW;
					csf_pkg::CSF_STK_PUSHP: state_nxt = S_PUSH_PSW;
					csf_pkg::CSF_STK_CALL: state_nxt = S_PUSH_PCH;
					csf_pkg::CSF_STK_RET: state_nxt = S_POP_PCL;
					csf_pkg::CSF_STK_MASKABLE_INTERRUPT_RETURN: state_nxt = S_POP_PCL;
					csf_pkg::CSF_STK_POPP: state_nxt = S_POP_PSW;
					default: state_nxt = S_IDLE;
				endcase
			end
			S_PUSH_PSW: state_nxt = (kind_r == csf_pkg::CSF_STK_INTR) ?
				S_PUSH_PCH : S_IDLE;
			S_PUSH_PCH: state_nxt = S_PUSH_PCL;
			S_PUSH_PCL: state_nxt = S_IDLE;
			S_POP_PCL: state_nxt = S_POP_PCH;
			S_POP_PCH: state_nxt = (kind_r == csf_pkg::CSF_STK_MASKABLE_INTERRUPT_RETURN) ?
				S_POP_PSW : S_IDLE;
			S_POP_PSW: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= S_IDLE;
			kind_r <= csf_pkg::CSF_STK_NONE;
			o_pc_load <= 1'b0;
			o_psw_load <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (take) kind_r <= i_req;
			o_pc_load <= (state_r == S_POP_PCH);
			o_psw_load <= (state_r == S_POP_PSW);
		end
	end

	// Stack pointer has no reset value; software loads it first
	always_ff @(posedge i_sys_clk) begin
		if (take) pc_r <= i_pc;
		if (take) psw_r <= i_psw;
		if (i_sp_load && idle) sp_r <= i_sp_data;
		else if (pushing) sp_r <= sp_r - 16'h0001;
		else if (popping) sp_r <= sp_r + 16'h0001;
		if (state_r == S_POP_PCL) o_pc[7:0] <= i_stk_rdata;
		if (state_r == S_POP_PCH) o_pc[15:8] <= i_stk_rdata;
		if (state_r == S_POP_PSW) o_psw <= i_stk_rdata;
	end

	// Pushes store at the free slot, pops read one above it
	assign o_stk_addr = popping ? sp_r + 16'h0001 : sp_r;
	assign o_stk_we = pushing;
	assign o_stk_re = popping;
	assign o_stk_wdata = (state_r == S_PUSH_PSW) ? psw_r :
		(state_r == S_PUSH_PCH) ? pc_r[15:8] : pc_r[7:0];
	assign o_busy = !idle;
	assign o_sp = sp_r;

endmodule : csf_stack_seq

`default_nettype wire

// [rtl/csf_status_core.sv]
// Status word, condition flags, bank select and stack control of the core
//
// Summary of operation
// - A 4-bit bank selector picks the current register bank; reset clears it.
// - The status word sits at special-function address 003F.
// - Reading gives flags in bits 7..4 and bank selector in bits 3..0.
// - Memory writes change only the bank selector; such a write sets jump status.
// - Reset sets jump status to one; other flags keep their value.
// - Interrupt entry pushes status word, then PC high, then PC low.
// - Interrupt return pops PC low, PC high, then status word with bank.
// - Call pushes two return PC bytes; return reloads PC from them.
// - Stack pointer is not reset; software loads it before use.
// - Zero flag set when 8- or 16-bit result or moved data is zero.
// - Bit set, clear and complement put inverse of old bit into zero flag.
// - Multiply tests product high byte; divide tests remainder for zero flag.
// - Carry flag is carry out of MSB on add, borrow on subtract.
// - Divide sets carry on zero divisor or quotient of 100 hex or more.
// - Shift and rotate through carry load carry with the bit shifted out.
// - Carry flag acts as boolean accumulator with set, clear, complement.
// - Half carry from bit 3 on 8-bit add, borrow from bit 4 on subtract.
// - Arithmetic, compare and test copy their zero or carry outcome to jump status.
// - True jumps need jump status one, false jumps zero; half carry never tested.
// - Load, exchange, swap and jump force jump status to one.
// - Divide splits a 16-bit pair by C: quotient low byte, remainder high.
// - Sixteen banks of eight 8-bit registers, also four 16-bit pairs.
`timescale 1ns/1ps
`default_nettype none

module csf_status_core (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire csf_pkg::csf_op_s i_op,
	output logic [15:0] o_result,
	output logic o_result_valid,
	input wire logic [15:0] i_mem_addr,
	input wire logic i_mem_wr,
	input wire logic i_mem_rd,
	input wire logic [7:0] i_mem_wdata,
	output logic [7:0] o_mem_rdata,
	output logic o_mem_hit,
	input wire logic [2:0] i_reg_idx,
	output logic [15:0] o_reg_addr,
	input wire logic i_jr_valid,
	input wire csf_pkg::csf_cc_e i_jr_cc,
	output logic o_jump_taken,
	input wire csf_pkg::csf_stk_e i_stk_req,
	input wire logic [15:0] i_pc,
	input wire logic i_sp_load,
	input wire logic [15:0] i_sp_data,
	input wire logic [7:0] i_stk_rdata,
	output logic o_stk_busy,
	output logic [15:0] o_sp,
	output logic [15:0] o_stk_addr,
	output logic o_stk_we,
	output logic o_stk_re,
	output logic [7:0] o_stk_wdata,
	output logic o_pc_load,
	output logic [15:0] o_pc,
	output logic [3:0] o_bank_selector,
	output logic [7:0] o_status_word
);
	// ****************************************
	// State
	// ****************************************
	logic [3:0] bank_selector_r;
	logic jump_status_flag_r;
	logic zero_flag_r, carry_flag_r, half_carry_flag_r;
	logic [15:0] result_r;
	logic result_valid_r;
	logic [7:0] mem_rdata_r;
	logic [15:0] res_nxt;
	logic zf_nxt, cf_nxt, hf_nxt, jf_nxt;
	logic upd_zf, upd_cf, upd_hf, upd_jf, upd_res;

	wire csf_pkg::csf_op_e op = i_op.op;
	wire logic [15:0] a = i_op.a;
	wire logic [15:0] b = i_op.b;

	wire logic [7:0] status_word = {jump_status_flag_r, zero_flag_r,
		carry_flag_r, half_carry_flag_r, bank_selector_r};

	// ****************************************
	// Stack sequencer
	// ****************************************
	logic psw_load;
	logic [7:0] psw_pop;

	csf_stack_seq u_stack (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_req(i_stk_req),
		.i_pc(i_pc),
		.i_psw(status_word),
		.i_sp_load(i_sp_load),
		.i_sp_data(i_sp_data),
		.i_stk_rdata(i_stk_rdata),
		.o_busy(o_stk_busy),
		.o_sp(o_sp),
		.o_stk_addr(o_stk_addr),
		.o_stk_we(o_stk_we),
		.o_stk_re(o_stk_re),
		.o_stk_wdata(o_stk_wdata),
		.o_pc_load(o_pc_load),
		.o_pc(o_pc),
		.o_psw_load(psw_load),
		.o_psw(psw_pop)
	);

	// ****************************************
	// Arithmetic
	// ****************************************
	wire logic cin = (op == csf_pkg::CSF_OP_ADDC || op == csf_pkg::CSF_OP_SUBB)
		? carry_flag_r : 1'b0;
	wire logic is_step = (op == csf_pkg::CSF_OP_INC) ||
		(op == csf_pkg::CSF_OP_DEC);
	wire logic [15:0] opb = is_step ? 16'h0001 : b;
	wire logic [8:0] add8 = {1'b0, a[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
	wire logic [8:0] sub8 = {1'b0, a[7:0]} - {1'b0, opb[7:0]} - {8'h00, cin};
	wire logic [16:0] add16 = {1'b0, a} + {1'b0, opb} + {16'h0000, cin};
	wire logic [16:0] sub16 = {1'b0, a} - {1'b0, opb} - {16'h0000, cin};
	wire logic [4:0] hadd = {1'b0, a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
	wire logic [4:0] hsub = {1'b0, a[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
	wire logic [15:0] product = a[7:0] * b[7:0];

	// Divide by the C register, taken from the low byte of b
	wire logic div_zero = (b[7:0] == 8'h00);
	wire logic [15:0] divisor = {8'h00, b[7:0]};
	wire logic [15:0] quot = div_zero ? 16'h0000 : a / divisor;
	wire logic [15:0] remd = div_zero ? 16'h0000 : a % divisor;
	wire logic div_err = div_zero || (quot[15:8] != 8'h00);

	wire logic [15:0] sum = i_op.wide ? add16[15:0] : {8'h00, add8[7:0]};
	wire logic [15:0] dif = i_op.wide ? sub16[15:0] : {8'h00, sub8[7:0]};
	wire logic sum_c = i_op.wide ? add16[16] : add8[8];
	wire logic dif_c = i_op.wide ? sub16[16] : sub8[8];

	// Result width decides which bits count toward zero
	function automatic logic is_zero(input logic [15:0] v, input logic w);
		is_zero = w ? (v == 16'h0000) : (v[7:0] == 8'h00);
	endfunction : is_zero

	logic [7:0] sb_result;
	logic sb_cf, sb_zf;

	csf_shift_bit u_shift_bit (
		.i_op(op),
		.i_data(a[7:0]),
		.i_bit_sel(i_op.bit_sel),
		.i_cf(carry_flag_r),
		.o_result(sb_result),
		.o_cf(sb_cf),
		.o_zf(sb_zf)
	);

	// ****************************************
	// Flag selection per operation
	// ****************************************
	always_comb begin
		res_nxt = a;
		zf_nxt = zero_flag_r;
		cf_nxt = carry_flag_r;
		hf_nxt = half_carry_flag_r;
		jf_nxt = jump_status_flag_r;
		upd_zf = 1'b0;
		upd_cf = 1'b0;
		upd_hf = 1'b0;
		upd_jf = 1'b0;
		upd_res = 1'b0;
		unique case (op)
			csf_pkg::CSF_OP_ADD, csf_pkg::CSF_OP_ADDC, csf_pkg::CSF_OP_INC: begin
				res_nxt = sum;
				zf_nxt = is_zero(sum, i_op.wide);
				cf_nxt = sum_c;
				hf_nxt = i_op.wide ? 1'b0 : hadd[4];
				jf_nxt = sum_c;
				{upd_res, upd_zf, upd_cf, upd_hf, upd_jf} = 5'h1F;
			end
			csf_pkg::CSF_OP_SUB, csf_pkg::CSF_OP_SUBB, csf_pkg::CSF_OP_DEC: begin
				res_nxt = dif;
				zf_nxt = is_zero(dif, i_op.wide);
				cf_nxt = dif_c;
				hf_nxt = i_op.wide ? 1'b0 : hsub[4];
				jf_nxt = dif_c;
				{upd_res, upd_zf, upd_cf, upd_hf, upd_jf} = 5'h1F;
			end
			csf_pkg::CSF_OP_CMP: begin
				zf_nxt = is_zero(dif, i_op.wide);
				cf_nxt = dif_c;
				hf_nxt = i_op.wide ? 1'b0 : hsub[4];
				jf_nxt = is_zero(dif, i_op.wide);
				{upd_zf, upd_cf, upd_hf, upd_jf} = 4'hF;
			end
			csf_pkg::CSF_OP_AND, csf_pkg::CSF_OP_OR, csf_pkg::CSF_OP_XOR: begin
				res_nxt = (op == csf_pkg::CSF_OP_AND) ? (a & b) :
					(op == csf_pkg::CSF_OP_OR) ? (a | b) : (a ^ b);
				zf_nxt = is_zero(res_nxt, i_op.wide);
				jf_nxt = zf_nxt;
				{upd_res, upd_zf, upd_jf} = 3'h7;
			end
			csf_pkg::CSF_OP_TEST: begin
				zf_nxt = sb_zf;
				jf_nxt = sb_zf;
				{upd_zf, upd_jf} = 2'h3;
			end
			csf_pkg::CSF_OP_LOAD: begin
				res_nxt = a;
				zf_nxt = is_zero(a, i_op.wide);
				jf_nxt = 1'b1;
				{upd_res, upd_zf, upd_jf} = 3'h7;
			end
			csf_pkg::CSF_OP_XCH, csf_pkg::CSF_OP_JUMP: begin
				jf_nxt = 1'b1;
				upd_jf = 1'b1;
			end
			csf_pkg::CSF_OP_SWAP: begin
				res_nxt = {8'h00, a[3:0], a[7:4]};
				jf_nxt = 1'b1;
				{upd_res, upd_jf} = 2'h3;
			end
			csf_pkg::CSF_OP_MUL: begin
				res_nxt = product;
				zf_nxt = (product[15:8] == 8'h00);
				jf_nxt = zf_nxt;
				{upd_res, upd_zf, upd_jf} = 3'h7;
			end
			csf_pkg::CSF_OP_DIV: begin
				// On an error the pair is left as it was
				res_nxt = div_err ? a : {remd[7:0], quot[7:0]};
				zf_nxt = (remd[7:0] == 8'h00);
				cf_nxt = div_err;
				jf_nxt = div_err;
				{upd_res, upd_zf, upd_cf, upd_jf} = 4'hF;
			end
			csf_pkg::CSF_OP_SHLC, csf_pkg::CSF_OP_SHRC,
			csf_pkg::CSF_OP_ROLC, csf_pkg::CSF_OP_RORC: begin
				res_nxt = {8'h00, sb_result};
				zf_nxt = (sb_result == 8'h00);
				cf_nxt = sb_cf;
				jf_nxt = sb_cf;
				{upd_res, upd_zf, upd_cf, upd_jf} = 4'hF;
			end
			csf_pkg::CSF_OP_BSET, csf_pkg::CSF_OP_BCLR, csf_pkg::CSF_OP_BCPL: begin
				res_nxt = {8'h00, sb_result};
				zf_nxt = sb_zf;
				jf_nxt = sb_zf;
				{upd_res, upd_zf, upd_jf} = 3'h7;
			end
			csf_pkg::CSF_OP_SETC, csf_pkg::CSF_OP_CLRC, csf_pkg::CSF_OP_CPLC: begin
				cf_nxt = (op == csf_pkg::CSF_OP_SETC) ? 1'b1 :
					(op == csf_pkg::CSF_OP_CLRC) ? 1'b0 : ~carry_flag_r;
				jf_nxt = 1'b1;
				{upd_cf, upd_jf} = 2'h3;
			end
			default: upd_res = 1'b0;
		endcase
	end

	// ****************************************
	// Status word storage
	// ****************************************
	wire logic op_go = i_op.valid;
	wire logic sfr_hit = (i_mem_addr == csf_pkg::STATUS_WORD_ADDR);
	wire logic sfr_wr = i_mem_wr && sfr_hit;

	// A stack restore outranks an operation, which outranks a memory write
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bank_selector_r <= csf_pkg::BANK_SEL_RESET;
			jump_status_flag_r <= csf_pkg::JF_RESET;
		end else if (psw_load) begin
			bank_selector_r <= psw_pop[3:0];
			jump_status_flag_r <= psw_pop[csf_pkg::JF_POS];
		end else begin
			if (sfr_wr) bank_selector_r <= i_mem_wdata[3:0];
			if (op_go && upd_jf) jump_status_flag_r <= jf_nxt;
			else if (sfr_wr) jump_status_flag_r <= 1'b1;
		end
	end

	// No reset here: these flags survive reset unchanged
	always_ff @(posedge i_sys_clk) begin
		if (psw_load) begin
			zero_flag_r <= psw_pop[csf_pkg::ZF_POS];
			carry_flag_r <= psw_pop[csf_pkg::CF_POS];
			half_carry_flag_r <= psw_pop[csf_pkg::HF_POS];
		end else if (op_go) begin
			if (upd_zf) zero_flag_r <= zf_nxt;
			if (upd_cf) carry_flag_r <= cf_nxt;
			if (upd_hf) half_carry_flag_r <= hf_nxt;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			result_r <= 16'h0000;
			result_valid_r <= 1'b0;
			mem_rdata_r <= 8'h00;
		end else begin
			result_valid_r <= op_go && upd_res;
			if (op_go && upd_res) result_r <= res_nxt;
			mem_rdata_r <= (i_mem_rd && sfr_hit) ? status_word : 8'h00;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	wire logic [15:0] bank_off = {9'h000, bank_selector_r, 3'h0};
	assign o_reg_addr = csf_pkg::BANK_AREA_BASE + bank_off +
		{13'h0000, i_reg_idx};

	assign o_jump_taken = i_jr_valid && (
		(i_jr_cc == csf_pkg::CSF_CC_T && jump_status_flag_r) ||
		(i_jr_cc == csf_pkg::CSF_CC_F && !jump_status_flag_r) ||
		(i_jr_cc == csf_pkg::CSF_CC_Z && zero_flag_r) ||
		(i_jr_cc == csf_pkg::CSF_CC_NZ && !zero_flag_r) ||
		(i_jr_cc == csf_pkg::CSF_CC_CY && carry_flag_r) ||
		(i_jr_cc == csf_pkg::CSF_CC_NC && !carry_flag_r));

	assign o_result = result_r;
	assign o_result_valid = result_valid_r;
	assign o_mem_rdata = mem_rdata_r;
	assign o_mem_hit = sfr_hit;
	assign o_bank_selector = bank_selector_r;
	assign o_status_word = status_word;

	// ****************************************
	// Checks
	// ****************************************
	AST_SFR_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		sfr_wr && !psw_load && !op_go |=> bank_selector_r ==
			$past(i_mem_wdata[3:0]) && jump_status_flag_r)
		else $error("status word write did not set bank and jump status");

	AST_SFR_READ: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_mem_rd && sfr_hit && !psw_load && !op_go && !sfr_wr |=>
			o_mem_rdata == $past(status_word))
		else $error("status word read returned wrong layout");

	AST_LOAD_JF: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		op_go && op == csf_pkg::CSF_OP_LOAD && !psw_load |=>
			jump_status_flag_r)
		else $error("load did not force jump status");

	AST_ADD_HF: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		op_go && op == csf_pkg::CSF_OP_ADD && !i_op.wide && !psw_load |=>
			half_carry_flag_r == ($past(a[3:0]) + $past(b[3:0]) > 5'd15))
		else $error("half carry wrong after 8-bit add");

	AST_DIV_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		op_go && op == csf_pkg::CSF_OP_DIV && b[7:0] == 8'h00 && !psw_load
			|=> carry_flag_r && o_result == $past(a))
		else $error("divide by zero did not raise carry");

	AST_JUMP_TRUE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_jr_valid && i_jr_cc == csf_pkg::CSF_CC_T |->
			o_jump_taken == jump_status_flag_r)
		else $error("true jump disagrees with jump status");

	AST_INT_ORDER: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!o_stk_busy && i_stk_req == csf_pkg::CSF_STK_INTR |=>
			o_stk_we && o_stk_wdata == $past(status_word) ##1
			o_stk_we && o_stk_wdata == $past(i_pc[15:8], 2) ##1
			o_stk_we && o_stk_wdata == $past(i_pc[7:0], 3) ##1 !o_stk_we)
		else $error("interrupt push order or length wrong");

	AST_CALL_LEN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!o_stk_busy && i_stk_req == csf_pkg::CSF_STK_CALL |=>
			o_stk_we [*2] ##1 !o_stk_busy)
		else $error("call did not push exactly two bytes");

	AST_SP_PUSH: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_stk_we |-> o_stk_addr == o_sp ##1 o_sp == $past(o_sp) - 16'h0001)
		else $error("push did not post-decrement stack pointer");

	AST_SP_POP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_stk_re |-> o_stk_addr == o_sp + 16'h0001 ##1 o_sp == $past(o_stk_addr))
		else $error("pop did not pre-increment stack pointer");

	AST_MASKABLE_INTERRUPT_RETURN_BANK: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!o_stk_busy && i_stk_req == csf_pkg::CSF_STK_MASKABLE_INTERRUPT_RETURN |=>
			o_stk_re ##1 o_stk_re ##1 o_stk_re ##2
			bank_selector_r == $past(i_stk_rdata[3:0], 2))
		else $error("interrupt return did not restore bank");

endmodule : csf_status_core

`default_nettype wire

// [shared/csf_pkg.sv]
// Shared constants and types for the status, flag and stack block
package csf_pkg;

	// ****************************************
	// Register map and layout
	// ****************************************
	localparam logic [15:0] STATUS_WORD_ADDR = 16'h003F;
	localparam logic [15:0] BANK_AREA_BASE = 16'h0040;
	localparam int BANK_SEL_LSB = 0;
	localparam int BANK_SEL_W = 4;
	localparam int FLAG_LSB = 4;
	localparam int JF_POS = 7;
	localparam int ZF_POS = 6;
	localparam int CF_POS = 5;
	localparam int HF_POS = 4;
	localparam int BANK_REGS = 8;
	localparam int BANK_COUNT = 16;
	localparam logic [3:0] BANK_SEL_RESET = 4'h0;
	localparam logic JF_RESET = 1'b1;

	// ****************************************
	// Operations reported by the decoder
	// ****************************************
	typedef enum logic [4:0] {
		CSF_OP_NONE, CSF_OP_ADD, CSF_OP_ADDC, CSF_OP_SUB, CSF_OP_SUBB,
		CSF_OP_CMP, CSF_OP_INC, CSF_OP_DEC, CSF_OP_AND, CSF_OP_OR,
		CSF_OP_XOR, CSF_OP_TEST, CSF_OP_LOAD, CSF_OP_XCH, CSF_OP_SWAP,
		CSF_OP_JUMP, CSF_OP_MUL, CSF_OP_DIV, CSF_OP_SHLC, CSF_OP_SHRC,
		CSF_OP_ROLC, CSF_OP_RORC, CSF_OP_BSET, CSF_OP_BCLR, CSF_OP_BCPL,
		CSF_OP_SETC, CSF_OP_CLRC, CSF_OP_CPLC
	} csf_op_e;

	// Conditions a relative jump may test; half carry is not one of them
	typedef enum logic [2:0] {
		CSF_CC_T, CSF_CC_F, CSF_CC_Z, CSF_CC_NZ, CSF_CC_CY, CSF_CC_NC
	} csf_cc_e;

	// Stack transfers
	typedef enum logic [2:0] {
		CSF_STK_NONE, CSF_STK_CALL, CSF_STK_INTR, CSF_STK_RET,
		CSF_STK_MASKABLE_INTERRUPT_RETURN, CSF_STK_PUSHP, CSF_STK_POPP
	} csf_stk_e;

	typedef struct packed {
		logic jf;
		logic zf;
		logic cf;
		logic hf;
	} csf_flags_s;

	typedef struct packed {
		logic valid;
		csf_op_e op;
		logic wide;
		logic [2:0] bit_sel;
		logic [15:0] a;
		logic [15:0] b;
	} csf_op_s;

endpackage : csf_pkg

// [tb/csf_status_core_tb.sv]
// Self-checking bench for the status, flag and stack block
`timescale 1ns/1ps
`default_nettype none
module csf_status_core_tb;
	logic clk = 1'b0, rstn = 1'b0, mw = 1'b0, mr = 1'b0, jv = 1'b0;
	logic spl = 1'b0, rv, hit, jt, busy, we, re, pcl, rv_seen;
	logic [15:0] ma = 16'h003F, pc = 16'h0000, spd = 16'h0200;
	logic [15:0] res, ra, sp, sa, opc, got_pc;
	logic [7:0] wd = 8'h00, mrd, swd, sw, s8, mem [0:1023];
	logic [3:0] bank;
	logic [2:0] ri = 3'h6;
	csf_pkg::csf_op_s op = '0;
	csf_pkg::csf_cc_e cc = csf_pkg::CSF_CC_T;
	csf_pkg::csf_stk_e sr = csf_pkg::CSF_STK_NONE;
	int err_count = 0, checks_done = 0, seed = 32'h25BE, i;
	// Pop data must be there in the strobe cycle, so it is combinational
	wire logic [7:0] rd = mem[sa[9:0]];
	csf_status_core csf_status_core_i (.i_sys_clk(clk), .i_rstn(rstn),
		.i_op(op), .o_result(res), .o_result_valid(rv), .i_mem_addr(ma),
		.i_mem_wr(mw), .i_mem_rd(mr), .i_mem_wdata(wd), .o_mem_rdata(mrd),
		.o_mem_hit(hit), .i_reg_idx(ri), .o_reg_addr(ra), .i_jr_valid(jv),
		.i_jr_cc(cc), .o_jump_taken(jt), .i_stk_req(sr), .i_pc(pc),
		.i_sp_load(spl), .i_sp_data(spd), .i_stk_rdata(rd),
		.o_stk_busy(busy), .o_sp(sp), .o_stk_addr(sa), .o_stk_we(we),
		.o_stk_re(re), .o_stk_wdata(swd), .o_pc_load(pcl), .o_pc(opc),
		.o_bank_selector(bank), .o_status_word(sw));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (we === 1'b1) mem[sa[9:0]] <= swd;
		if (pcl === 1'b1) got_pc <= opc;
	end
	// ****************************************
	// Bus tasks and compares
	// ****************************************
	task automatic chk(input string n, input logic [15:0] e, g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chb(input string n, input logic e, g);
		chk(n, {15'h0000, e}, {15'h0000, g});
	endtask : chb
	task automatic tally_and_finish();
		if (err_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// Extra idle cycle keeps two drives of valid out of one time step
	task automatic run(input csf_pkg::csf_op_e o, input logic [15:0] a, b);
		op <= '{1'b1, o, 1'b0, b[2:0], a, b};
		@(negedge clk) op.valid <= 1'b0;
		rv_seen = rv;
		@(negedge clk);
	endtask : run
	task automatic rb(input csf_pkg::csf_op_e o, input logic [15:0] a, b,
		input int p, input logic e);
		run(o, a, b);
		chb(o.name(), e, sw[p]);
	endtask : rb
	task automatic wr(input logic [7:0] d);
		mw <= 1'b1;
		wd <= d;
		chb("hit", 1'b1, hit);
		@(negedge clk) mw <= 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic jp(input csf_pkg::csf_cc_e c, input logic e);
		cc <= c;
		#1 chb(c.name(), e, jt);
		@(negedge clk);
	endtask : jp
	task automatic arith(input logic sub, input logic [7:0] a, b);
		logic [8:0] s;
		logic [3:0] f;
		s = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
		f[0] = sub ? a[3:0] < b[3:0] : {1'b0, a[3:0]} + b[3:0] > 5'h0F;
		f[3:1] = {s[8], s[7:0] == 8'h00, s[8]};
		run(sub ? csf_pkg::CSF_OP_SUB : csf_pkg::CSF_OP_ADD, {8'h00, a}, b);
		chk("sum", {8'h00, s[7:0]}, {8'h00, res[7:0]});
		chb("valid", 1'b1, rv_seen);
		chk("flags", {12'h000, f}, {12'h000, sw[7:4]});
	endtask : arith
	// Waits out a stack sequence; a hang ends the run
	task automatic stk(input csf_pkg::csf_stk_e r, input logic [15:0] p);
		sr <= r;
		pc <= p;
		@(negedge clk) sr <= csf_pkg::CSF_STK_NONE;
		for (int n = 0; busy !== 1'b0; n++) begin
			if (n > 8) begin
				err_count++;
				tally_and_finish();
			end
			@(negedge clk);
		end
		repeat (2) @(negedge clk);
	endtask : stk
	initial begin
		repeat (8) @(negedge clk);
		chk("bank", 16'h0000, {12'h000, bank});
		chb("jf", 1'b1, sw[7]);
		rstn <= 1'b1;
		@(negedge clk);
		arith(1'b0, 8'h19, 8'h28);
		arith(1'b0, 8'hFF, 8'h01);
		arith(1'b1, 8'h00, 8'h01);
		for (i = 0; i < 24; i++)
			arith(i[0], 8'($random(seed)), 8'($random(seed)));
		s8 = sw;
		wr(8'hF5);
		chk("bank", 16'h0005, {12'h000, bank});
		chk("keep", {13'h0000, s8[6:4]}, {13'h0000, sw[6:4]});
		chb("jf", 1'b1, sw[7]);
		mr <= 1'b1;
		@(negedge clk) mr <= 1'b0;
		chk("rdata", {8'h00, sw[7:4], 4'h5}, {8'h00, mrd});
		chk("reg addr", 16'h006E, ra);
		rb(csf_pkg::CSF_OP_MUL, 16'h0012, 16'h0034, 6, 1'b0);
		rb(csf_pkg::CSF_OP_MUL, 16'h0005, 16'h0003, 6, 1'b1);
		rb(csf_pkg::CSF_OP_DIV, 16'h0105, 16'h0010, 5, 1'b0);
		chk("div", 16'h0510, res);
		rb(csf_pkg::CSF_OP_DIV, 16'h0100, 16'h0010, 6, 1'b1);
		rb(csf_pkg::CSF_OP_DIV, 16'h1234, 16'h0000, 5, 1'b1);
		rb(csf_pkg::CSF_OP_DIV, 16'h1000, 16'h0010, 5, 1'b1);
		rb(csf_pkg::CSF_OP_CLRC, 16'h0080, 16'h0000, 5, 1'b0);
		rb(csf_pkg::CSF_OP_CPLC, 16'h0080, 16'h0000, 5, 1'b1);
		rb(csf_pkg::CSF_OP_SHRC, 16'h0080, 16'h0000, 5, 1'b0);
		rb(csf_pkg::CSF_OP_SETC, 16'h0000, 16'h0000, 5, 1'b1);
		rb(csf_pkg::CSF_OP_SHLC, 16'h0000, 16'h0000, 5, 1'b0);
		rb(csf_pkg::CSF_OP_BSET, 16'h0020, 16'h0005, 6, 1'b0);
		rb(csf_pkg::CSF_OP_BCLR, 16'h0000, 16'h0005, 6, 1'b1);
		rb(csf_pkg::CSF_OP_LOAD, 16'h0055, 16'h0000, 7, 1'b1);
		jv <= 1'b1;
		jp(csf_pkg::CSF_CC_T, 1'b1);
		arith(1'b0, 8'h01, 8'h01);
		jp(csf_pkg::CSF_CC_T, 1'b0);
		jp(csf_pkg::CSF_CC_F, 1'b1);
		jp(csf_pkg::CSF_CC_Z, 1'b0);
		jp(csf_pkg::CSF_CC_NZ, 1'b1);
		jp(csf_pkg::CSF_CC_CY, 1'b0);
		jp(csf_pkg::CSF_CC_NC, 1'b1);
		jv <= 1'b0;
		spl <= 1'b1;
		@(negedge clk) spl <= 1'b0;
		stk(csf_pkg::CSF_STK_CALL, 16'hABCD);
		chk("sp", 16'h01FE, sp);
		chk("call", 16'hABCD, {mem[512], mem[511]});
		stk(csf_pkg::CSF_STK_RET, 16'h0000);
		chk("ret", 16'hABCD, got_pc);
		chk("sp", 16'h0200, sp);
		s8 = sw;
		stk(csf_pkg::CSF_STK_INTR, 16'h1234);
		chk("intr", {s8, 8'h12}, {mem[512], mem[511]});
		chk("sp", 16'h01FD, sp);
		wr(8'h09);
		stk(csf_pkg::CSF_STK_MASKABLE_INTERRUPT_RETURN, 16'h0000);
		chk("maskable_interrupt_return", 16'h1234, got_pc);
		chk("status", {8'h00, s8}, {8'h00, sw});
		tally_and_finish();
	end
endmodule : csf_status_core_tb
`default_nettype wire
